/* File: hw/dpr_defs.svh */
// Constants for the dual port block memory: sizes, reserved word, resets.
// Included by bare name from the package and the block memory module.
`ifndef DPR_DEFS_SVH
`define DPR_DEFS_SVH

// Array geometry
`define DPR_ADDR_W 8
`define DPR_DATA_W 16
`define DPR_DEPTH 256

// Word that configuration preload can never set
`define DPR_NOLOAD_LOC 8'h00

// Reset values of port registers
`define DPR_RDDATA_RST 16'h0000
`define DPR_LOC_RST 8'h00
`define DPR_WORD_RST 16'h0000
`define DPR_INH_RST 16'hFFFF

`endif

/* File: hw/dpr_pkg.sv */
// Types shared by the dual port block memory, its user model and its bench.
// Assumes dpr_defs.svh is reachable on the include path.
`include "dpr_defs.svh"

package dpr_pkg;

  typedef logic [`DPR_ADDR_W-1:0] dpr_loc_t;
  typedef logic [`DPR_DATA_W-1:0] dpr_word_t;

  // Everything user logic presents on the write port
  typedef struct packed {
    logic gate;
    logic clockGate;
    dpr_loc_t location;
    dpr_word_t data;
    dpr_word_t inhibit;
  } dpr_wr_port_s;

  // Everything user logic presents on the read port
  typedef struct packed {
    logic gate;
    logic clockGate;
    dpr_loc_t location;
  } dpr_rd_port_s;

  // Configuration-time preload stream
  typedef struct packed {
    logic strobe;
    dpr_loc_t location;
    dpr_word_t data;
  } dpr_preload_s;

endpackage

/* File: hw/dpr_edge_det.sv */
// Finds the active edge of a port clock that arrives as a sampled level.
// Assumes the level is already synchronous to clk.
`timescale 1ns/1ps

module dpr_edge_det (
  input wire logic clk,
  input wire logic rst,
  input wire logic level,
  input wire logic fallingSel,
  output logic activeEdge
);

  logic prev_reg;
  logic primed_reg;
  logic rose;
  logic fell;

  // Previous sample; primed blocks a false edge right after reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prev_reg <= 1'b0;
      primed_reg <= 1'b0;
    end else begin
      prev_reg <= level;
      primed_reg <= 1'b1;
    end
  end

  // Edge decode and polarity selection
  assign rose = primed_reg & ~prev_reg & level;
  assign fell = primed_reg & prev_reg & ~level;
  assign activeEdge = fallingSel ? fell : rose;

endmodule

/* File: hw/dpr_block_ram.sv */
// Dual port block memory: 256 x 16 array, write port with per-bit
// inhibit, independent read port, configuration-time preload.
// Assumes all inputs, including both port clocks, are synchronous to clk.
`timescale 1ns/1ps
`include "dpr_defs.svh"

// Summary of operation
// - Array is 256 words of 16 bits
// - 8-bit write location picks the target word
// - Independent 8-bit read location picks output word
// - Inhibit bit 1 keeps that stored bit
// - Inputs registered at array on port's edge
// - Write port rising edge, optional falling edge
// - Read port rising edge, optional falling edge
// - Contents optionally preloaded during configuration
// - Preload never sets word zero
module dpr_block_ram #(
  parameter int DATA_W = `DPR_DATA_W,
  parameter int ADDR_W = `DPR_ADDR_W,
  parameter int DEPTH = `DPR_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic wrClock,
  input wire logic wrFallingEdge,
  input wire dpr_pkg::dpr_wr_port_s wrPort,
  input wire logic rdClock,
  input wire logic rdFallingEdge,
  input wire dpr_pkg::dpr_rd_port_s rdPort,
  input wire logic cfgActive,
  input wire dpr_pkg::dpr_preload_s preload,
  output logic [DATA_W-1:0] rdData
);

  // Geometry is fixed by the port structs; refuse anything else
  if (DATA_W != `DPR_DATA_W || ADDR_W != `DPR_ADDR_W ||
      DEPTH != (1 << ADDR_W)) begin : gBadGeometry
    $error("dpr_block_ram: unsupported geometry");
  end

  logic [DATA_W-1:0] mem [DEPTH];

  logic wrEdge;
  logic rdEdge;
  logic wrFire;
  logic rdFire;
  logic wrPend_reg;
  logic [ADDR_W-1:0] wrLoc_reg;
  logic [DATA_W-1:0] wrData_reg;
  logic [DATA_W-1:0] wrInh_reg;
  logic rdPend_reg;
  logic [ADDR_W-1:0] rdLoc_reg;
  logic [DATA_W-1:0] rdData_reg;
  logic [DATA_W-1:0] curWord;
  logic [DATA_W-1:0] mergedWord;
  logic [DATA_W-1:0] rdWord;
  logic [DATA_W-1:0] word0;
  logic preloadOk;
  logic userWrite;

  // Port clock edge detectors with selectable polarity
  dpr_edge_det wrEdgeDet (
    .clk(clk),
    .rst(rst),
    .level(wrClock),
    .fallingSel(wrFallingEdge),
    .activeEdge(wrEdge)
  );

  dpr_edge_det rdEdgeDet (
    .clk(clk),
    .rst(rst),
    .level(rdClock),
    .fallingSel(rdFallingEdge),
    .activeEdge(rdEdge)
  );

  // The user write port is held off while configuration owns the array; the read port is not
  assign wrFire = wrEdge & wrPort.gate & wrPort.clockGate &
    ~cfgActive;
  assign rdFire = rdEdge & rdPort.gate & rdPort.clockGate;
  assign preloadOk = cfgActive & preload.strobe &
    (preload.location != `DPR_NOLOAD_LOC);
  assign userWrite = wrPend_reg & ~cfgActive;
  assign curWord = mem[wrLoc_reg];
  assign rdWord = mem[rdLoc_reg];
  assign word0 = mem[0];

  // Per-bit merge: inhibited bits keep the stored value
  genvar b;
  generate
    for (b = 0; b < DATA_W; b++) begin : gMerge
      assign mergedWord[b] = wrInh_reg[b] ? curWord[b] : wrData_reg[b];
    end
  endgenerate

  // Write port input registers, loaded only on a qualified edge
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPend_reg <= 1'b0;
      wrLoc_reg <= `DPR_LOC_RST;
      wrData_reg <= `DPR_WORD_RST;
      wrInh_reg <= `DPR_INH_RST;
    end else begin
      wrPend_reg <= wrFire;
      if (wrFire) begin
        wrLoc_reg <= wrPort.location;
        wrData_reg <= wrPort.data;
        wrInh_reg <= wrPort.inhibit;
      end
    end
  end

  // Array write; preload wins since user writes are off in configuration
  always_ff @(posedge clk) begin
    if (preloadOk) begin
      mem[preload.location] <= preload.data;
    end else if (userWrite) begin
      mem[wrLoc_reg] <= mergedWord;
    end
  end

  // Read port: location registered on the edge, data one clk later
  always_ff @(posedge clk) begin
    if (rst) begin
      rdPend_reg <= 1'b0;
      rdLoc_reg <= `DPR_LOC_RST;
      rdData_reg <= `DPR_RDDATA_RST;
    end else begin
      rdPend_reg <= rdFire;
      if (rdFire) begin
        rdLoc_reg <= rdPort.location;
      end
      if (rdPend_reg) begin
        rdData_reg <= rdWord;
      end
    end
  end

  assign rdData = rdData_reg;

  // A qualified write edge registers the location and data
  property p_wr_capture;
    @(posedge clk) disable iff (rst)
    wrFire |=> wrPend_reg && wrLoc_reg == $past(wrPort.location) &&
      wrData_reg == $past(wrPort.data);
  endproperty
  a_wr_capture: assert property (p_wr_capture)
    else $error("write inputs not registered on edge");

  // No write without both gates
  property p_wr_gated;
    @(posedge clk) disable iff (rst)
    (wrEdge && !(wrPort.gate && wrPort.clockGate)) |=> !wrPend_reg;
  endproperty
  a_wr_gated: assert property (p_wr_gated)
    else $error("write taken without both gates");

  // Uninhibited bits take the new data
  property p_wr_bits;
    @(posedge clk) disable iff (rst)
    userWrite && !preloadOk |=>
      ((mem[$past(wrLoc_reg)] ^ $past(wrData_reg)) & ~$past(wrInh_reg)) == '0;
  endproperty
  a_wr_bits: assert property (p_wr_bits)
    else $error("written bits do not match data");

  // Inhibited bits keep the old word
  property p_wr_keep;
    @(posedge clk) disable iff (rst)
    userWrite && !preloadOk |=>
      ((mem[$past(wrLoc_reg)] ^ $past(curWord)) & $past(wrInh_reg)) == '0;
  endproperty
  a_wr_keep: assert property (p_wr_keep)
    else $error("inhibited bit changed");

  // Edges fire only at the selected polarity
  property p_wr_edge;
    @(posedge clk) disable iff (rst)
    wrEdge |-> (wrClock == !wrFallingEdge) &&
      ($past(wrClock) == wrFallingEdge);
  endproperty
  a_wr_edge: assert property (p_wr_edge)
    else $error("write edge at wrong polarity");

  property p_rd_edge;
    @(posedge clk) disable iff (rst)
    rdEdge |-> (rdClock == !rdFallingEdge) &&
      ($past(rdClock) == rdFallingEdge);
  endproperty
  a_rd_edge: assert property (p_rd_edge)
    else $error("read edge at wrong polarity");

  // Read: location taken, then addressed word appears two clks on
  sequence s_rd_issue;
    rdFire ##1 (rdPend_reg && !preloadOk && !userWrite);
  endsequence
  property p_rd_update;
    @(posedge clk) disable iff (rst)
    s_rd_issue |=> rdData_reg == $past(rdWord);
  endproperty
  a_rd_update: assert property (p_rd_update)
    else $error("read data not the addressed word");

  // Output holds when no read is pending
  property p_rd_hold;
    @(posedge clk) disable iff (rst)
    !rdPend_reg |=> $stable(rdData_reg);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data changed without a read");

  // Preload lands, but never in word zero
  property p_preload;
    @(posedge clk) disable iff (rst)
    preloadOk |=> mem[$past(preload.location)] == $past(preload.data);
  endproperty
  a_preload: assert property (p_preload)
    else $error("preload word not stored");

  property p_preload_zero;
    @(posedge clk) disable iff (rst)
    (cfgActive && preload.strobe && preload.location == `DPR_NOLOAD_LOC)
      |=> $stable(word0);
  endproperty
  a_preload_zero: assert property (p_preload_zero)
    else $error("preload changed word zero");

endmodule

/* File: verif/dpr_user_model.sv */
// Fabric user logic on both ports of the block memory.
// Assumes the bench calls its tasks; port clocks are levels on clk.
`timescale 1ns/1ps

module dpr_user_model (
  input wire logic clk,
  output logic wrClock,
  output dpr_pkg::dpr_wr_port_s wrPort,
  output logic rdClock,
  output dpr_pkg::dpr_rd_port_s rdPort
);
  // Idle: clocks still, write gates off so the array is never touched
  initial begin
    wrClock = 1'b0;
    rdClock = 1'b0;
    wrPort = '0;
    rdPort = '0;
  end

  // Whole write clock pulse, fields held across both edges
  task automatic wr(input dpr_pkg::dpr_wr_port_s p);
    @(posedge clk);
    wrPort <= p;
    wrClock <= 1'b1;
    @(posedge clk);
    wrClock <= 1'b0;
    @(posedge clk);
    // Released fields flip so a stale value cannot pass for a good one
    wrPort <= {2'b00, ~p.location, ~p.data, ~p.inhibit};
  endtask

  // Whole read clock pulse
  task automatic rd(input dpr_pkg::dpr_rd_port_s p);
    @(posedge clk);
    rdPort <= p;
    rdClock <= 1'b1;
    @(posedge clk);
    rdClock <= 1'b0;
    @(posedge clk);
    rdPort <= {2'b00, ~p.location};
  endtask
endmodule

/* File: verif/dpr_block_ram_tb_top.sv */
// Self-checking bench for the dual port block memory.
// Assumes the user model file is compiled first.
`timescale 1ns/1ps

module dpr_block_ram_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wrClock, rdClock, cfgActive = 1'b0;
  logic wrFallingEdge = 1'b0;
  logic rdFallingEdge = 1'b0;
  dpr_pkg::dpr_wr_port_s wrPort;
  dpr_pkg::dpr_rd_port_s rdPort;
  dpr_pkg::dpr_preload_s preload = '0;
  logic [15:0] rdData;
  int n_mismatch = 0;
  int n_tests = 0;

  // 250 MHz system clock
  initial begin
    forever #2 clk = ~clk;
  end

  dpr_user_model model_u (.clk(clk), .wrClock(wrClock), .wrPort(wrPort),
    .rdClock(rdClock), .rdPort(rdPort));

  dpr_block_ram dut_u (.clk(clk), .rst(rst), .wrClock(wrClock),
    .wrFallingEdge(wrFallingEdge), .wrPort(wrPort), .rdClock(rdClock),
    .rdFallingEdge(rdFallingEdge), .rdPort(rdPort), .cfgActive(cfgActive),
    .preload(preload), .rdData(rdData));

  task automatic tally_and_finish();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write, then let the input register stage commit before anything else
  task automatic wg(input logic g, cg, input logic [7:0] l,
                    input logic [15:0] d, m);
    model_u.wr({g, cg, l, d, m});
    repeat (2) @(posedge clk);
  endtask

  // Read and compare once the answer has landed in either edge mode
  task automatic rchk(input logic [7:0] l, input logic [15:0] e);
    model_u.rd({2'b11, l});
    repeat (3) @(posedge clk);
    #1 chk(rdData, e);
  endtask

  // Reset held four cycles; output clears, array keeps its words
  task automatic t_reset();
    @(posedge clk) rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk(rdData, 16'h0000);
  endtask

  // Preload skips word zero; user writes are blocked meanwhile
  task automatic t_preload();
    logic [7:0] locs [4] = '{8'h00, 8'h01, 8'h02, 8'hFF};
    logic [15:0] vals [4] = '{16'hDEAD, 16'hA5A5, 16'h0F0F, 16'h5A5A};
    wg(1'b1, 1'b1, 8'h00, 16'h1234, 16'h0000);
    @(posedge clk) cfgActive <= 1'b1;
    foreach (locs[i]) begin
      @(posedge clk) preload <= {1'b1, locs[i], vals[i]};
    end
    @(posedge clk) preload <= {1'b0, 8'h55, 16'h5555};
    wg(1'b1, 1'b1, 8'h02, 16'hBEEF, 16'h0000);
    @(posedge clk) cfgActive <= 1'b0;
    rchk(8'h00, 16'h1234);
    rchk(8'h01, 16'hA5A5);
    rchk(8'hFF, 16'h5A5A);
    rchk(8'h02, 16'h0F0F);
  endtask

  // Per-bit inhibit and independent locations
  task automatic t_mask();
    wg(1'b1, 1'b1, 8'h05, 16'hFFFF, 16'h0000);
    wg(1'b1, 1'b1, 8'h05, 16'h0000, 16'h00FF);
    wg(1'b1, 1'b1, 8'h06, 16'h1111, 16'h0000);
    rchk(8'h05, 16'h00FF);
    rchk(8'h06, 16'h1111);
  endtask

  // Either write gate low keeps the word; either read gate low holds data
  task automatic t_gates();
    for (int i = 0; i < 2; i++) begin
      wg(i[0], ~i[0], 8'h05, 16'h0000, 16'h0000);
      rchk(8'h05, 16'h00FF);
    end
    rchk(8'h06, 16'h1111);
    model_u.rd({2'b01, 8'h05});
    model_u.rd({2'b10, 8'h05});
    repeat (3) @(posedge clk);
    #1 chk(rdData, 16'h1111);
  endtask

  // Falling-edge mode: the read answers one cycle later than rising
  task automatic t_fall();
    @(posedge clk);
    wrFallingEdge <= 1'b1;
    rdFallingEdge <= 1'b1;
    repeat (2) @(posedge clk);
    wg(1'b1, 1'b1, 8'h07, 16'hCAFE, 16'h0000);
    model_u.rd({2'b11, 8'h07});
    // A rising-edge read would already show the new word here
    #1 chk(rdData, 16'h1111);
    @(posedge clk);
    #1 chk(rdData, 16'hCAFE);
    @(posedge clk);
    wrFallingEdge <= 1'b0;
    rdFallingEdge <= 1'b0;
  endtask

  initial begin
    t_reset();
    t_preload();
    t_mask();
    t_gates();
    t_fall();
    t_reset();
    rchk(8'h05, 16'h00FF);
    tally_and_finish();
  end

  // Whole run is well under a thousand cycles
  initial begin
    #20000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule
